//--- logic/sfid_core.v
// Identification command decoder and serial shifter of the flash
`timescale 1ns/100ps
`default_nettype none
`include "sfid_map.vh"
module sfid_core #(
  // Identity codes, values arbitrary
  parameter [7:0] MAKER_CODE = 8'hA5,
  parameter [7:0] PART_CODE = 8'h5C,
  parameter [7:0] SIG_CODE = 8'h5C,
  parameter TABLE_BYTES = 16,
  parameter INFO_BYTES = 16
) (
  // Clock and control
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  // Serial pins
  input wire i_sck,
  input wire i_cs_n,
  input wire i_si,
  output reg o_so,
  output reg o_so_oe,
  // Device state
  input wire i_busy,
  // Command side effects
  output reg o_soft_reset,
  output reg o_mode_exit
);
  // ==========================================
  // Pin synchronisers and edges
  // Reset values match idle pins, no false edge
  reg [1:0] sck_sync;
  reg [1:0] cs_sync;
  reg [1:0] si_sync;
  reg sck_prev;
  wire sck_rise;
  wire sck_fall;
  wire cs_n;
  assign sck_rise = sck_sync[1] && !sck_prev;
  assign sck_fall = !sck_sync[1] && sck_prev;
  assign cs_n = cs_sync[1];
  always @(posedge i_clk) begin
    if (i_reset) begin
      sck_sync <= 2'b00;
      cs_sync <= 2'b11;
      si_sync <= 2'b00;
      sck_prev <= 1'b0;
    end else if (i_ce) begin
      sck_sync <= {sck_sync[0], i_sck};
      cs_sync <= {cs_sync[0], i_cs_n};
      si_sync <= {si_sync[0], i_si};
      sck_prev <= sck_sync[1];
    end
  end

  // ==========================================
  // Byte stores
  function [7:0] info_byte;
    input [7:0] idx;
    begin
      case (idx)
        8'h00: info_byte = MAKER_CODE;
        8'h01: info_byte = 8'h20;
        8'h02: info_byte = PART_CODE;
        8'h03: info_byte = 8'h4D;
        8'h04: info_byte = 8'h00;
        8'h05: info_byte = 8'h80;
        8'h10: info_byte = 8'h51;
        8'h11: info_byte = 8'h52;
        8'h12: info_byte = 8'h59;
        default: info_byte = 8'h00;
      endcase
    end
  endfunction
  function [7:0] table_byte;
    input [7:0] idx;
    begin
      case (idx)
        8'h00: table_byte = 8'h53;
        8'h01: table_byte = 8'h46;
        8'h02: table_byte = 8'h44;
        8'h03: table_byte = 8'h50;
        8'h04: table_byte = 8'h00;
        8'h05: table_byte = 8'h01;
        8'h06: table_byte = 8'h00;
        8'h07: table_byte = 8'hFF;
        default: table_byte = 8'hFF;
      endcase
    end
  endfunction

  // ==========================================
  // Command state
  localparam [2:0] ST_CMD = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_DUMMY = 3'd2;
  localparam [2:0] ST_OUT = 3'd3;
  localparam [2:0] ST_IGNORE = 3'd4;
  localparam [1:0] MD_PAIR = 2'd0;
  localparam [1:0] MD_FULL = 2'd1;
  localparam [1:0] MD_SIG = 2'd2;
  localparam [1:0] MD_TABLE = 2'd3;

  reg [2:0] state;
  reg [1:0] mode;
  reg [7:0] cmd_shift;
  reg [23:0] addr;
  reg [4:0] bit_cnt;
  reg [7:0] ptr;
  reg [2:0] out_bit;
  reg [7:0] out_byte;
  reg pending_act;
  wire [7:0] cmd_next;
  assign cmd_next = {cmd_shift[6:0], si_sync[1]};

  // ==========================================
  // Byte FIFO between fetch and shifter
  reg fetch_valid;
  reg [7:0] fetch_data;
  wire fetch_ready;
  wire q_valid;
  wire [7:0] q_data;
  wire q_take;
  wire in_out;
  assign in_out = (state == ST_OUT);
  assign q_take = in_out && sck_fall && (out_bit == 3'd0) && q_valid;

  // Queue flushed while deselected
  sfid_fifo #(
    .WIDTH(8),
    .DEPTH(`SFID_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_flush(cs_n),
    .i_in_valid(fetch_valid),
    .i_in_data(fetch_data),
    .o_in_ready(fetch_ready),
    .o_out_valid(q_valid),
    .o_out_data(q_data),
    .i_out_ready(q_take)
  );

  // Next byte for the current command
  always @* begin
    fetch_data = 8'h00;
    case (mode)
      MD_PAIR: fetch_data = ptr[0] ? PART_CODE : MAKER_CODE;
      MD_FULL: fetch_data = info_byte(ptr);
      MD_SIG: fetch_data = SIG_CODE;
      MD_TABLE: fetch_data = table_byte(ptr);
      default: fetch_data = 8'h00;
    endcase
  end
  // Prefetch runs ahead of the shifter
  always @* begin
    fetch_valid = in_out && !cs_n;
  end

  // ==========================================
  // Sequencer
  always @(posedge i_clk) begin
    if (i_reset) begin
      state <= ST_CMD;
      mode <= MD_PAIR;
      cmd_shift <= 8'h00;
      addr <= 24'h00_0000;
      bit_cnt <= 5'd0;
      ptr <= 8'h00;
      out_bit <= 3'd0;
      out_byte <= 8'h00;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      o_soft_reset <= 1'b0;
      o_mode_exit <= 1'b0;
      pending_act <= 1'b0;
    end else if (i_ce) begin
      o_soft_reset <= 1'b0;
      o_mode_exit <= 1'b0;
      if (cs_n) begin
        state <= ST_CMD;
        bit_cnt <= 5'd0;
        out_bit <= 3'd0;
        o_so_oe <= 1'b0;
        if (pending_act) begin
          o_soft_reset <= (cmd_shift == `SFID_CMD_RESET) || (cmd_shift == `SFID_CMD_RESET_ALT);
          o_mode_exit <= (cmd_shift == `SFID_CMD_MODE_RST);
        end
        pending_act <= 1'b0;
      end else begin
        if (fetch_valid && fetch_ready) begin
          ptr <= (mode == MD_PAIR) ? {7'd0, ~ptr[0]} : ptr + 8'd1;
        end
        case (state)
          ST_CMD: begin
            if (sck_rise) begin
              cmd_shift <= cmd_next;
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == 5'd7) begin
                bit_cnt <= 5'd0;
                ptr <= 8'h00;
                addr <= 24'h00_0000;
                case (cmd_next)
                  `SFID_CMD_PAIR: begin
                    mode <= MD_PAIR;
                    state <= ST_ADDR;
                  end
                  `SFID_CMD_FULL: begin
                    mode <= MD_FULL;
                    state <= i_busy ? ST_IGNORE : ST_OUT;
                  end
                  `SFID_CMD_SIG: begin
                    mode <= MD_SIG;
                    state <= ST_ADDR;
                  end
                  `SFID_CMD_TABLE: begin
                    mode <= MD_TABLE;
                    state <= ST_ADDR;
                  end
                  `SFID_CMD_RESET, `SFID_CMD_RESET_ALT, `SFID_CMD_MODE_RST: begin
                    pending_act <= 1'b1;
                    state <= ST_IGNORE;
                  end
                  default: state <= ST_IGNORE;
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (sck_rise) begin
              addr <= {addr[22:0], si_sync[1]};
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == 5'd23) begin
                bit_cnt <= 5'd0;
                case (mode)
                  MD_PAIR: begin
                    ptr <= ({addr[22:0], si_sync[1]} == `SFID_SWAP_ADDR) ? 8'h01 : 8'h00;
                    state <= ST_OUT;
                  end
                  MD_SIG: state <= ST_OUT;
                  MD_TABLE: begin
                    ptr <= {addr[6:0], si_sync[1]};
                    state <= ST_DUMMY;
                  end
                  default: state <= ST_OUT;
                endcase
              end
            end
          end
          ST_DUMMY: begin
            if (sck_rise) begin
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == 5'd7) begin
                bit_cnt <= 5'd0;
                state <= ST_OUT;
              end
            end
          end
          ST_OUT: begin
            if (sck_fall) begin
              o_so_oe <= 1'b1;
              // Byte boundary pulls next byte
              if (out_bit == 3'd0) begin
                o_so <= q_data[7];
                out_byte <= {q_data[6:0], 1'b0};
              end else begin
                o_so <= out_byte[7];
                out_byte <= {out_byte[6:0], 1'b0};
              end
              out_bit <= out_bit + 3'd1;
            end
          end
          ST_IGNORE: begin
            // Rest of frame discarded
            state <= ST_IGNORE;
          end
          default: state <= ST_CMD;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/sfid_map.vh
// Constants for the serial flash identification command block
// How it works
// - 90h plus address returns maker then part
// - Identification bytes leave most significant first
// - Address 000001h sends part before maker
// - Pair alternates until chip select rises
// - 9Fh returns maker, part, extended, structure bytes
// - Identity read ignored while operation busy
// - Past structure end data is undefined
// - Chip select high stops identity output
// - ABh plus three dummies returns signature
// - Signature bits change on falling edge
// - Signature repeats every eight clocks
// - Chip select high ends signature read
// - 5Ah, address, eight dummies, then table
// - Table read starts at supplied address
// - Reserved legacy codes accepted, no action
// - Reset returns defaults; mode reset exits
`ifndef SFID_MAP_VH
`define SFID_MAP_VH
`define SFID_CMD_PAIR 8'h90
`define SFID_CMD_FULL 8'h9F
`define SFID_CMD_SIG 8'hAB
`define SFID_CMD_TABLE 8'h5A
`define SFID_CMD_RESET 8'hF0
`define SFID_CMD_RESET_ALT 8'h0F
`define SFID_CMD_MODE_RST 8'hFF
`define SFID_CMD_RSV_A3 8'hA3
`define SFID_CMD_RSV_18 8'h18
`define SFID_CMD_RSV_E5 8'hE5
`define SFID_CMD_RSV_E6 8'hE6
`define SFID_SWAP_ADDR 24'h00_0001
`define SFID_ADDR_BITS 24
`define SFID_SIG_DUMMY_BITS 24
`define SFID_TABLE_DUMMY_BITS 8
`define SFID_FIFO_DEPTH 8
`endif

//--- logic/sfid_fifo.v
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sfid_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and control
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  input wire i_flush,
  // Fill side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // Drain side
  output wire o_out_valid,
  output reg [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;
  always @* begin
    o_out_data = mem[rd_ptr];
  end
  always @(posedge i_clk) begin
    if (i_reset || (i_ce && i_flush)) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (i_ce) begin
      if (do_wr) begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/sfid_core_asserts.sv
// Pin-level checks for the identification command block
`timescale 1ns/100ps
`default_nettype none
module sfid_core_asserts (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Serial pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe,
  // State and side effects
  input wire logic i_busy,
  input wire logic o_soft_reset,
  input wire logic o_mode_exit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ====================
  // Frame end and output start
  sequence s_frame_over;
    i_cs_n && $past(i_cs_n, 2);
  endsequence
  sequence s_oe_start;
    !i_cs_n && !$past(i_sck);
  endsequence
  chk_oe_cs_off: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("output enable held after deselect");
  chk_so_on_fall: assert property ((o_so_oe && $changed(o_so)) |-> !$past(i_sck))
    else $error("output bit changed outside low clock phase");
  chk_so_hold_high: assert property ((i_sck && $past(i_sck, 3)) |-> $stable(o_so))
    else $error("output bit moved while clock high");
  chk_oe_start_fall: assert property ($rose(o_so_oe) |-> s_oe_start)
    else $error("output enable rose outside a falling edge");
  chk_oe_end_cs: assert property ($fell(o_so_oe) |-> $past(i_cs_n, 2))
    else $error("output enable dropped while selected");
  chk_reset_pulse_end: assert property (o_soft_reset |-> s_frame_over ##1 !o_soft_reset)
    else $error("soft reset pulse misplaced");
  chk_mode_pulse_end: assert property (o_mode_exit |-> s_frame_over ##0 !o_soft_reset ##1 !o_mode_exit)
    else $error("mode exit pulse misplaced");
  chk_idle_so_quiet: assert property (i_cs_n [*6] |-> $stable(o_so))
    else $error("output moved between frames");
endmodule
bind sfid_core sfid_core_asserts chk_u (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .i_busy(i_busy),
  .o_soft_reset(o_soft_reset), .o_mode_exit(o_mode_exit));
`default_nettype wire

//--- bench/sfid_host.sv
// Serial host model that issues one command frame at a time
`timescale 1ns/100ps
`default_nettype none
module sfid_host (
  // Serial pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  logic [63:0] rx;
  logic seen_oe;
  integer i;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    rx = 64'h0;
    seen_oe = 1'b0;
  end
  // ====================
  // slow clock, idle low
  task xfer(input logic [39:0] hdr, input integer nin, input integer nout);
    begin
      rx = 64'h0;
      seen_oe = 1'b0;
      o_cs_n = 1'b0;
      for (i = 0; i < nin + nout; i = i + 1) begin
        o_si = (i < nin) ? hdr[39 - i] : ~o_si;
        #160 o_sck = 1'b1;
        seen_oe = seen_oe | i_so_oe;
        // Released line reads high
        if (i >= nin) rx = {rx[62:0], i_so_oe ? i_so : 1'b1};
        #160 o_sck = 1'b0;
      end
      #160;
      o_cs_n = 1'b1;
      o_si = ~o_si;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/test_spi_flash_identification_cmds.sv
// Self-checking bench for the identification command block
`timescale 1ns/100ps
`default_nettype none
module test_spi_flash_identification_cmds;
  // Identity values, arbitrary
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [7:0] PART = 8'hC6;
  localparam logic [7:0] SIG = 8'h96;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_busy = 1'b0;
  logic ce = 1'b1;
  wire sck, cs_n, si, so, so_oe, soft_reset, mode_exit;
  integer failures = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer n_soft = 0;
  integer n_mode = 0;
  logic [63:0] keep;
  always #20 i_clk = ~i_clk;
  sfid_core #(.MAKER_CODE(MAKER), .PART_CODE(PART), .SIG_CODE(SIG)) dut_u (.i_clk(i_clk), .i_reset(i_reset),
    .i_ce(ce), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_busy(i_busy),
    .o_soft_reset(soft_reset), .o_mode_exit(mode_exit));
  sfid_host host_u (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (soft_reset === 1'b1) n_soft <= n_soft + 1;
    if (mode_exit === 1'b1) n_mode <= n_mode + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("checks %0d errors %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task idle;
    begin
      repeat (12) @(posedge i_clk);
      #1;
    end
  endtask
  // ====================
  // Scenarios
  task t_pair;
    integer a;
    begin
      for (a = 0; a < 2; a = a + 1) begin
        host_u.xfer({8'h90, 23'h0, a[0], 8'h00}, 32, 32);
        idle;
        chk("pair ids", a ? {32'h0, PART, MAKER, PART, MAKER} : {32'h0, MAKER, PART, MAKER, PART}, host_u.rx);
        chk("oe after frame", 64'h0, {63'h0, so_oe});
      end
    end
  endtask
  task t_full;
    begin
      host_u.xfer({8'h9F, 32'h0}, 8, 16);
      idle;
      chk("full maker", {56'h0, MAKER}, {56'h0, host_u.rx[15:8]});
      i_busy = 1'b1;
      host_u.xfer({8'h9F, 32'h0}, 8, 16);
      idle;
      i_busy = 1'b0;
      chk("busy oe", 64'h0, {63'h0, host_u.seen_oe});
      chk("busy line", {48'h0, 16'hFFFF}, host_u.rx);
    end
  endtask
  task t_sig;
    begin
      host_u.xfer({8'hAB, 32'h0}, 32, 24);
      idle;
      chk("signature", {40'h0, SIG, SIG, SIG}, host_u.rx);
    end
  endtask
  task t_table;
    begin
      host_u.xfer({8'h5A, 32'h0}, 40, 32);
      idle;
      keep = host_u.rx;
      chk("table oe", 64'h1, {63'h0, host_u.seen_oe});
      host_u.xfer({8'h5A, 24'h00_0002, 8'h00}, 40, 16);
      idle;
      chk("table offset", {48'h0, keep[15:0]}, host_u.rx);
    end
  endtask
  task t_cmds;
    logic [55:0] codes;
    integer k;
    integer s0;
    integer m0;
    begin
      codes = 56'hF0_0FFF_A318_E5E6;
      for (k = 0; k < 7; k = k + 1) begin
        s0 = n_soft;
        m0 = n_mode;
        host_u.xfer({codes[55 - 8 * k -: 8], 32'h0}, 8, 8);
        idle;
        chk("soft pulses", {63'h0, k < 2}, n_soft - s0);
        chk("mode pulses", {63'h0, k == 2}, n_mode - m0);
        chk("reserved quiet", 64'h0, {63'h0, host_u.seen_oe});
      end
    end
  endtask
  task t_ce;
    begin
      ce = 1'b0;
      host_u.xfer({8'hAB, 32'h0}, 32, 8);
      idle;
      ce = 1'b1;
      chk("frozen oe", 64'h0, {63'h0, host_u.seen_oe});
      idle;
      host_u.xfer({8'hAB, 32'h0}, 32, 8);
      idle;
      chk("thawed signature", {56'h0, SIG}, host_u.rx);
    end
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_reset = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    t_pair;
    t_full;
    t_sig;
    t_table;
    t_cmds;
    t_ce;
    stop_test;
  end
endmodule
`default_nettype wire
